// ==== include/gcsr_pkg.sv ====
// constants, types and register map of the command status and chroma-key block
`default_nettype none
package gcsr_pkg;
   //------------------------------------------------------------
   // register offsets
   //------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL     = 12'h000; // control
   localparam logic [11:0] OFS_STATUS   = 12'h004; // status
   localparam logic [11:0] OFS_CUR_INFO = 12'h008; // current info
   localparam logic [11:0] OFS_CUR_LEN  = 12'h00C; // current length
   localparam logic [11:0] OFS_CUR_CNT  = 12'h010; // current count
   localparam logic [11:0] OFS_PRV_INFO = 12'h014; // previous info
   localparam logic [11:0] OFS_PRV_LEN  = 12'h018; // previous length
   localparam logic [11:0] OFS_PRV_CNT  = 12'h01C; // previous count
   localparam logic [11:0] OFS_KEY_HI   = 12'h020; // upper bounds
   localparam logic [11:0] OFS_KEY_LO   = 12'h024; // lower bounds
   //------------------------------------------------------------
   // control field positions
   //------------------------------------------------------------
   localparam int CTL_EN      = 0;  // engine enable
   localparam int CTL_RESTART = 1;  // restart, self clearing
   localparam int CTL_ABORT   = 2;  // abort, self clearing
   localparam int CTL_BPP_LO  = 4;  // depth select, 2 bits
   localparam int CTL_KEN_LO  = 8;  // component enables b,g,r
   //------------------------------------------------------------
   // status field positions
   //------------------------------------------------------------
   localparam int STS_ERR_LO = 4;  // error code, 4 bits
   localparam int STS_WRM    = 8;  // write master idle
   localparam int STS_RDM    = 9;  // read master idle
   //------------------------------------------------------------
   // values and counts
   //------------------------------------------------------------
   localparam logic [31:0] RST_WORD     = 32'h0000_0000; // word reset
   localparam logic [23:0] RST_KEY      = 24'h00_0000;   // bound reset
   localparam logic [2:0]  RST_KEN      = 3'h7;          // all enabled
   localparam logic [31:0] BYTES_PER_RD = 32'h0000_0004; // per read
   localparam logic [3:0]  ERR_NONE     = 4'h0;          // no error
   localparam logic [3:0]  ERR_ABT_NULL = 4'hE;          // abort, none
   localparam logic [3:0]  ERR_ABT_CMD  = 4'hF;          // abort, started
   localparam logic [7:0]  MSK_FULL     = 8'hFF;         // all bits
   localparam logic [7:0]  MSK_FIVE     = 8'hF8;         // upper five
   localparam logic [7:0]  MSK_SIX      = 8'hFC;         // upper six
   //------------------------------------------------------------
   // types
   //------------------------------------------------------------
   typedef enum logic [1:0] {
      PS_IDLE   = 2'b00,
      PS_ACTIVE = 2'b01,
      PS_STALL  = 2'b10
   } gcsr_pstate_t;

   typedef enum logic [1:0] {
      BPP_24 = 2'b00,
      BPP_16 = 2'b01,
      BPP_8  = 2'b10
   } gcsr_bpp_t;

   typedef struct packed {
      logic [31:0] info;  // command word
      logic [31:0] len;   // length word
      logic [31:0] cnt;   // bytes fetched
   } gcsr_cmd_t;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } gcsr_rgb_t;
endpackage : gcsr_pkg
`default_nettype wire

// ==== logic/gcsr_top.sv ====
// command status, recovery and chroma-key compare behind an APB slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module gcsr_top
   import gcsr_pkg::*;
#(
   parameter int ADDR_W = 12  // apb address width
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]  pwdata,
   output var  logic [31:0]  prdata,
   output var  logic         pready,
   output var  logic         pslverr,
   input  wire logic         fifo_rd,
   input  wire logic [31:0]  fifo_data,
   input  wire logic         cmd_done,
   input  wire logic         cmd_error,
   input  wire logic [3:0]   cmd_error_code,
   input  wire logic         wr_master_idle,
   input  wire logic         rd_master_idle,
   input  wire logic         pix_valid,
   input  wire gcsr_rgb_t    pix_rgb,
   output var  logic         engine_enable,
   output var  gcsr_pstate_t parser_state,
   output var  logic         key_valid,
   output var  logic         key_match
);
   //------------------------------------------------------------
   // elaboration check
   //------------------------------------------------------------
   if (ADDR_W < 6 || ADDR_W > 12) begin : g_chk
      $error("ADDR_W must lie in 6..12");
   end

   //------------------------------------------------------------
   // state of the block
   //------------------------------------------------------------
   typedef struct packed {
      logic         en;        // engine enable
      gcsr_bpp_t    bpp;       // pixel depth
      logic [2:0]   ken;       // component enables r,g,b
      gcsr_pstate_t ps;        // parser state
      logic         hdr;       // header taken, length awaited
      logic [3:0]   err;       // error code
      gcsr_cmd_t    cur;       // current command
      gcsr_cmd_t    prv;       // last completed command
      gcsr_rgb_t    khi;       // upper bounds
      gcsr_rgb_t    klo;       // lower bounds
      logic         rdy;       // apb answer
      logic         serr;      // apb error
      logic [31:0]  rdat;      // apb read data
      logic         kval;      // compare result valid
      logic         kmat;      // compare result
   } gcsr_state_t;

   gcsr_state_t st_q;  // registered state
   gcsr_state_t st_d;  // next state

   //------------------------------------------------------------
   // functions
   //------------------------------------------------------------
   // inclusive range test on the masked bits
   function automatic logic in_range(
      input logic [7:0] v,
      input logic [7:0] lo,
      input logic [7:0] hi,
      input logic [7:0] m
   );
      in_range = ((v & m) >= (lo & m)) && ((v & m) <= (hi & m));
   endfunction : in_range

   // exact match of an address against one register offset
   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [11:0]       ofs
   );
      hit = (12'(a) == ofs);
   endfunction : hit

   //------------------------------------------------------------
   // read views, apb handshake, mask and control wires
   //------------------------------------------------------------
   logic [31:0] ctrl_word;  // control read view
   logic [31:0] stat_word;  // status read view
   logic        acc;        // access phase awaiting answer
   logic        commit;     // edge at which the access completes
   logic        wr_ok;      // write takes effect now
   logic [7:0]  mr;         // red mask
   logic [7:0]  mg;         // green mask
   logic [7:0]  mb;         // blue mask
   logic        use_r;      // red takes part
   logic        use_g;      // green takes part
   logic        use_b;      // blue takes part
   logic        en_new;     // enable value after this write
   logic        clr;        // restart or enable rise

   //------------------------------------------------------------
   // next-state logic
   //------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      acc    = psel && penable && !st_q.rdy;
      commit = psel && penable && st_q.rdy;
      wr_ok  = commit && pwrite && !st_q.serr;

      // read views
      ctrl_word = RST_WORD;
      ctrl_word[CTL_EN] = st_q.en;
      ctrl_word[CTL_BPP_LO +: 2] = st_q.bpp;
      ctrl_word[CTL_KEN_LO +: 3] = st_q.ken;
      stat_word = RST_WORD;
      stat_word[1:0] = st_q.ps;
      stat_word[STS_ERR_LO +: 4] = st_q.err;
      stat_word[STS_WRM] = wr_master_idle;
      stat_word[STS_RDM] = rd_master_idle;

      // apb answer: one wait state, data and error set together
      st_d.rdy  = acc;
      st_d.serr = 1'b0;      // error and data stand only with pready
      st_d.rdat = RST_WORD;
      if (acc) begin
         if (hit(paddr, OFS_CTRL)) begin
            st_d.rdat = ctrl_word;
         end else if (hit(paddr, OFS_STATUS)) begin
            st_d.rdat = stat_word;
         end else if (hit(paddr, OFS_CUR_INFO)) begin
            st_d.rdat = st_q.cur.info;
         end else if (hit(paddr, OFS_CUR_LEN)) begin
            st_d.rdat = st_q.cur.len;
         end else if (hit(paddr, OFS_CUR_CNT)) begin
            st_d.rdat = st_q.cur.cnt;
         end else if (hit(paddr, OFS_PRV_INFO)) begin
            st_d.rdat = st_q.prv.info;
         end else if (hit(paddr, OFS_PRV_LEN)) begin
            st_d.rdat = st_q.prv.len;
         end else if (hit(paddr, OFS_PRV_CNT)) begin
            st_d.rdat = st_q.prv.cnt;
         end else if (hit(paddr, OFS_KEY_HI)) begin
            st_d.rdat = {8'h00, st_q.khi};
         end else if (hit(paddr, OFS_KEY_LO)) begin
            st_d.rdat = {8'h00, st_q.klo};
         end else begin
            st_d.serr = 1'b1;  // unmapped address
         end
      end

      // parser tracking from the command FIFO
      case (st_q.ps)
         PS_IDLE: begin
            if (fifo_rd && !st_q.hdr) begin
               st_d.cur.info = fifo_data;                  // header word
               st_d.cur.cnt  = BYTES_PER_RD;
               st_d.hdr      = 1'b1;
            end else if (fifo_rd) begin
               st_d.cur.len = fifo_data;
               st_d.cur.cnt = st_q.cur.cnt + BYTES_PER_RD;
               st_d.hdr     = 1'b0;
               st_d.ps      = PS_ACTIVE;
            end
         end
         PS_ACTIVE: begin
            if (cmd_error) begin
               st_d.ps  = PS_STALL;
               st_d.err = cmd_error_code;
            end else if (cmd_done) begin
               st_d.prv.len  = st_q.cur.len;
               st_d.prv.info = st_q.cur.info;
               st_d.prv.cnt  = fifo_rd ? st_q.cur.cnt + BYTES_PER_RD
                                       : st_q.cur.cnt;
               st_d.cur      = '0;
               st_d.ps       = PS_IDLE;
            end else if (fifo_rd) begin
               st_d.cur.cnt = st_q.cur.cnt + BYTES_PER_RD;
            end
         end
         PS_STALL: begin
            st_d.ps = PS_STALL;  // FIFO reads ignored while stalled
         end
         default: begin
            st_d.ps = PS_IDLE;
         end
      endcase

      // control writes
      en_new = st_q.en;
      clr    = 1'b0;
      if (wr_ok && hit(paddr, OFS_CTRL)) begin
         en_new     = pwdata[CTL_EN];
         st_d.en    = pwdata[CTL_EN];
         st_d.bpp   = gcsr_bpp_t'(pwdata[CTL_BPP_LO +: 2]);
         st_d.ken   = pwdata[CTL_KEN_LO +: 3];
         clr        = pwdata[CTL_RESTART] || (en_new && !st_q.en);
         if (pwdata[CTL_ABORT] && !clr) begin
            // abort: header-less idle reads null, else keep started command
            st_d.ps = PS_STALL;
            if (st_q.ps == PS_IDLE && !st_q.hdr) begin
               st_d.err = ERR_ABT_NULL;
               st_d.cur = '0;
            end else begin
               st_d.err = ERR_ABT_CMD;
               st_d.cur = st_q.cur;
            end
            st_d.prv = st_q.prv;
            st_d.hdr = 1'b0;
         end
      end
      if (wr_ok && hit(paddr, OFS_KEY_HI)) begin
         st_d.khi = pwdata[23:0];
      end
      if (wr_ok && hit(paddr, OFS_KEY_LO)) begin
         st_d.klo = pwdata[23:0];
      end

      // restart or enable rise overrides any same-cycle completion
      if (clr) begin
         st_d.cur = '0;
         st_d.prv = '0;
         st_d.ps  = PS_IDLE;
         st_d.hdr = 1'b0;
         st_d.err = ERR_NONE;
      end

      // component masks per pixel depth
      case (st_q.bpp)
         BPP_16: begin
            mr = MSK_FIVE;
            mg = MSK_SIX;
            mb = MSK_FIVE;
            use_r = st_q.ken[2];
            use_g = st_q.ken[1];
         end
         BPP_8: begin
            mr = MSK_FULL;
            mg = MSK_FULL;
            mb = MSK_FULL;
            use_r = 1'b0;
            use_g = 1'b0;
         end
         default: begin
            mr = MSK_FULL;
            mg = MSK_FULL;
            mb = MSK_FULL;
            use_r = st_q.ken[2];
            use_g = st_q.ken[1];
         end
      endcase
      use_b = st_q.ken[0];

      // chroma-key compare, one cycle after the pixel
      st_d.kval = pix_valid;
      if (pix_valid) begin
         st_d.kmat =
            (!use_r || in_range(pix_rgb.red, st_q.klo.red, st_q.khi.red, mr)) &&
            (!use_g || in_range(pix_rgb.green, st_q.klo.green, st_q.khi.green, mg)) &&
            (!use_b || in_range(pix_rgb.blue, st_q.klo.blue, st_q.khi.blue, mb));
      end
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= '0;
         st_q.ken  <= RST_KEN;
         st_q.bpp  <= BPP_24;
         st_q.ps   <= PS_IDLE;
         st_q.err  <= ERR_NONE;
         st_q.prv  <= '0;
         st_q.khi  <= RST_KEY;
         st_q.klo  <= RST_KEY;
         st_q.rdat <= RST_WORD;
      end else begin
         st_q <= st_d;
      end
   end

   //------------------------------------------------------------
   // outputs straight from the state register
   //------------------------------------------------------------
   always_comb begin
      prdata        = st_q.rdat;
      pready        = st_q.rdy;
      pslverr       = st_q.serr;
      engine_enable = st_q.en;
      parser_state  = st_q.ps;
      key_valid     = st_q.kval;
      key_match     = st_q.kmat;
   end
endmodule : gcsr_top
`default_nettype wire

// ==== dv/gcsr_cmd_src.sv ====
// command queue and coprocessor model that feeds the parser side
`timescale 1ns/10ps
`default_nettype none
module gcsr_cmd_src (
   input  wire logic        pclk,
   output var  logic        fifo_rd,
   output var  logic [31:0] fifo_data,
   output var  logic        cmd_done,
   output var  logic        cmd_error,
   output var  logic [3:0]  cmd_error_code,
   output var  logic        wr_master_idle,
   output var  logic        rd_master_idle
);
   initial begin
      fifo_rd        = 1'b0;
      fifo_data      = 32'h0;
      cmd_done       = 1'b0;
      cmd_error      = 1'b0;
      cmd_error_code = 4'h0;
      wr_master_idle = 1'b1;
      rd_master_idle = 1'b1;
   end
   // one queue word per call; the data bus is not left showing the old word
   task automatic word(input logic [31:0] d);
      @(posedge pclk);
      fifo_rd   <= 1'b1;
      fifo_data <= d;
      @(posedge pclk);
      fifo_rd   <= 1'b0;
      fifo_data <= ~d;
   endtask : word
   // coprocessor finishes, or fails with a code
   task automatic fin(input logic err, input logic [3:0] c);
      @(posedge pclk);
      cmd_done       <= !err;
      cmd_error      <= err;
      cmd_error_code <= c;
      @(posedge pclk);
      cmd_done       <= 1'b0;
      cmd_error      <= 1'b0;
      cmd_error_code <= ~c;
   endtask : fin
   // memory masters settle slowly, read side lags the write side
   task automatic masters(input logic idle);
      @(posedge pclk);
      wr_master_idle <= idle;
      repeat (3) @(posedge pclk);
      rd_master_idle <= idle;
   endtask : masters
endmodule : gcsr_cmd_src
`default_nettype wire

// ==== dv/gcsr_top_asserts.sv ====
// concurrent checks on the status and chroma-key block ports
`timescale 1ns/10ps
`default_nettype none
module gcsr_top_asserts
   import gcsr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              cmd_done,
   input wire logic              cmd_error,
   input wire logic              pix_valid,
   input wire logic              engine_enable,
   input wire gcsr_pstate_t      parser_state,
   input wire logic              key_valid,
   input wire logic              key_match
);
   logic ctl_w; // control write commits at this edge
   assign ctl_w = psel && penable && pready && pwrite && (paddr == ADDR_W'(OFS_CTRL));
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("slave error without pready");
   a_key_follows: assert property (pix_valid |=> key_valid)
      else $error("no compare result after pixel");
   a_key_holds: assert property (!pix_valid |=> $stable(key_match) && !key_valid)
      else $error("compare result moved without pixel");
   a_done_to_idle: assert property (parser_state == PS_ACTIVE && cmd_done && !cmd_error && !ctl_w
      |=> parser_state == PS_IDLE)
      else $error("completion did not return parser to idle");
   a_error_stalls: assert property (parser_state == PS_ACTIVE && cmd_error && !cmd_done && !ctl_w
      |=> parser_state == PS_STALL)
      else $error("command error did not stall");
   a_stall_holds: assert property (parser_state == PS_STALL && !ctl_w
      |=> parser_state == PS_STALL)
      else $error("stall left without restart");
   a_abort_stalls: assert property (ctl_w && pwdata[CTL_ABORT] && !pwdata[CTL_RESTART]
      && !(pwdata[CTL_EN] && !engine_enable) |=> parser_state == PS_STALL)
      else $error("abort did not stall the parser");
   a_restart_idles: assert property (ctl_w && pwdata[CTL_RESTART] |=> parser_state == PS_IDLE)
      else $error("restart did not idle the parser");
endmodule : gcsr_top_asserts
bind gcsr_top gcsr_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .cmd_done, .cmd_error, .pix_valid,
   .engine_enable, .parser_state, .key_valid, .key_match);
`default_nettype wire

// ==== dv/tb_gcsr_top.sv ====
// self-checking bench for the status, recovery and chroma-key block
`timescale 1ns/10ps
`default_nettype none
module tb_gcsr_top;
   import gcsr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pix_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fifo_data, q;
   logic pready, pslverr, fifo_rd, cmd_done, cmd_error, wr_master_idle, rd_master_idle;
   logic engine_enable, key_valid, key_match, e;
   logic [3:0] cmd_error_code;
   gcsr_pstate_t parser_state;
   gcsr_rgb_t pix_rgb, h, l, p;
   logic [1:0] bp;
   logic [2:0] kn;
   int seed, n_fail, checks, n;
   gcsr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .fifo_rd, .fifo_data, .cmd_done, .cmd_error, .cmd_error_code, .wr_master_idle,
      .rd_master_idle, .pix_valid, .pix_rgb, .engine_enable, .parser_state, .key_valid,
      .key_match);
   gcsr_cmd_src src (.pclk, .fifo_rd, .fifo_data, .cmd_done, .cmd_error, .cmd_error_code,
      .wr_master_idle, .rd_master_idle);
   always #5 pclk = ~pclk;
   task automatic close_out();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   // one apb transfer: setup, access held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic s);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      s = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic s;
      apb(1'b1, a, d, r, s);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic s;
      apb(1'b0, a, 32'h0, r, s);
      chk(r, x);
   endtask : rd
   function automatic logic [31:0] mk(input logic en, rs, ab, input logic [1:0] b,
                                      input logic [2:0] k);
      return {21'h0, k, 2'h0, b, 1'b0, ab, rs, en};
   endfunction : mk
   function automatic logic inb(input logic [7:0] v, lo, hi, m);
      return ((v & m) >= (lo & m)) && ((v & m) <= (hi & m));
   endfunction : inb
   // expected match: masked per depth, enabled components anded, blue alone at 8 bpp
   function automatic logic kexp(input gcsr_rgb_t v, hi, lo, input logic [1:0] b,
                                 input logic [2:0] k);
      logic [7:0] m5, m6;
      m5 = (b == 2'd1) ? 8'hF8 : 8'hFF;
      m6 = (b == 2'd1) ? 8'hFC : 8'hFF;
      if (b == 2'd2) return inb(v.blue, lo.blue, hi.blue, 8'hFF);
      return (inb(v.red, lo.red, hi.red, m5) || !k[2]) && (inb(v.green, lo.green, hi.green, m6)
         || !k[1]) && (inb(v.blue, lo.blue, hi.blue, m5) || !k[0]);
   endfunction : kexp
   task automatic pix(input gcsr_rgb_t v, input logic x);
      @(posedge pclk);
      pix_valid <= 1'b1;
      pix_rgb   <= v;
      @(posedge pclk);
      pix_valid <= 1'b0;
      pix_rgb   <= ~v;
      @(posedge pclk);
      chk({31'h0, key_valid}, 32'h1);
      chk({31'h0, key_match}, {31'h0, x});
   endtask : pix
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      close_out();
   end
   initial begin
      pclk      = 1'b0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      pix_valid = 1'b0;
      paddr     = 12'h0;
      pwdata    = 32'h0;
      pix_rgb   = 24'h0;
      seed = 40;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_PRV_LEN, 32'h0);
      rd(OFS_PRV_CNT, 32'h0);
      rd(OFS_KEY_HI, 32'h0);
      rd(OFS_KEY_LO, 32'h0);
      wr(OFS_KEY_HI, 32'hFFFF_FFFF);
      rd(OFS_KEY_HI, 32'h00FF_FFFF);
      wr(OFS_KEY_LO, 32'hA5C3_3C5A);
      rd(OFS_KEY_LO, 32'h00C3_3C5A);
      wr(OFS_PRV_LEN, 32'h1234_5678);
      rd(OFS_PRV_LEN, 32'h0);
      apb(1'b0, 12'h028, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      // random keys and pixels over all depths, exact-key corner every fourth pass
      for (int i = 0; i < 60; i++) begin
         h  = 24'($random(seed));
         l  = (i % 4 == 0) ? h : 24'($random(seed));
         bp = 2'(i % 3);
         kn = 3'($random(seed));
         if (kn == 3'h0 || bp == 2'd2) kn[0] = 1'b1;
         n  = $random(seed);
         p  = (n[1:0] == 2'd0) ? l : (n[1:0] == 2'd1) ? h : 24'($random(seed));
         wr(OFS_KEY_HI, {8'h0, h});
         wr(OFS_KEY_LO, {8'h0, l});
         wr(OFS_CTRL, mk(1'b0, 1'b0, 1'b0, bp, kn));
         pix(p, kexp(p, h, l, bp, kn));
      end
      // a full command, then one aborted in its body
      wr(OFS_CTRL, mk(1'b1, 1'b0, 1'b0, 2'd0, 3'h7));
      src.masters(1'b0);
      src.word(32'h0001_00A1);
      rd(OFS_STATUS, 32'h0);
      src.word(32'h0000_0010);
      rd(OFS_STATUS, 32'h1);
      src.word(32'h1111_1111);
      src.word(32'h2222_2222);
      src.fin(1'b0, 4'h0);
      rd(OFS_PRV_INFO, 32'h0001_00A1);
      rd(OFS_PRV_LEN, 32'h0000_0010);
      rd(OFS_PRV_CNT, 32'h0000_0010);
      rd(OFS_CUR_LEN, 32'h0);
      src.word(32'h0002_00B2);
      src.word(32'h0000_0020);
      src.word(32'h3333_3333);
      wr(OFS_CTRL, mk(1'b1, 1'b0, 1'b1, 2'd0, 3'h7));
      rd(OFS_STATUS, 32'h0000_00F2);
      chk({30'h0, parser_state}, 32'h2);
      rd(OFS_CUR_INFO, 32'h0002_00B2);
      rd(OFS_CUR_CNT, 32'h0000_000C);
      rd(OFS_PRV_LEN, 32'h0000_0010);
      src.word(32'h4444_4444);
      src.fin(1'b0, 4'h0);
      rd(OFS_PRV_CNT, 32'h0000_0010);
      // recovery: masters idle, enable off, restart, enable back on
      fork
         src.masters(1'b1);
      join_none
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, q, e);
         n++;
      end while (q[9:8] !== 2'b11 && n < 20);
      chk({30'h0, q[9:8]}, 32'h3);
      wr(OFS_CTRL, mk(1'b0, 1'b0, 1'b0, 2'd0, 3'h7));
      // queue flush and endpoint halt clear are done outside this block
      wr(OFS_CTRL, mk(1'b0, 1'b1, 1'b0, 2'd0, 3'h7));
      rd(OFS_PRV_INFO, 32'h0);
      rd(OFS_PRV_CNT, 32'h0);
      wr(OFS_CTRL, mk(1'b1, 1'b0, 1'b0, 2'd0, 3'h7));
      src.word(32'h0003_00C3);
      src.word(32'h0000_0008);
      src.fin(1'b0, 4'h0);
      rd(OFS_PRV_INFO, 32'h0003_00C3);
      rd(OFS_PRV_CNT, 32'h0000_0008);
      // restart lands on the same edge as a completion
      src.word(32'h0004_00D4);
      src.word(32'h0000_0004);
      fork
         wr(OFS_CTRL, mk(1'b1, 1'b1, 1'b0, 2'd0, 3'h7));
         begin
            repeat (2) @(posedge pclk);
            src.fin(1'b0, 4'h0);
         end
      join
      rd(OFS_PRV_LEN, 32'h0);
      // command error stalls, then abort from idle gives the null code
      src.word(32'h0005_00E5);
      src.word(32'h0000_0004);
      src.fin(1'b1, 4'h5);
      rd(OFS_STATUS, 32'h0000_0352);
      wr(OFS_CTRL, mk(1'b1, 1'b1, 1'b0, 2'd0, 3'h7));
      wr(OFS_CTRL, mk(1'b1, 1'b0, 1'b1, 2'd0, 3'h7));
      rd(OFS_STATUS, 32'h0000_03E2);
      rd(OFS_CUR_INFO, 32'h0);
      wr(OFS_CTRL, mk(1'b1, 1'b1, 1'b0, 2'd0, 3'h7));
      // enable rising edge clears the previous command
      src.word(32'h0006_00F6);
      src.word(32'h0000_0004);
      src.fin(1'b0, 4'h0);
      rd(OFS_PRV_LEN, 32'h0000_0004);
      wr(OFS_CTRL, mk(1'b0, 1'b0, 1'b0, 2'd0, 3'h7));
      wr(OFS_CTRL, mk(1'b1, 1'b0, 1'b0, 2'd0, 3'h7));
      rd(OFS_PRV_LEN, 32'h0);
      chk({31'h0, engine_enable}, 32'h1);
      close_out();
   end
endmodule : tb_gcsr_top
`default_nettype wire
